//--- rtl/arb_pkg.sv
package arb_pkg;

    // register byte offsets
    localparam logic [11:0] cpu_ctrl_offset = 12'h000;
    localparam logic [11:0] pci_ctrl_offset = 12'h004;

    // cpu control field positions
    localparam int cpu_active_pos = 0;
    localparam int cpu_park_pos   = 1;
    localparam int cpu_order_pos  = 3;
    localparam int cpu_fsw_pos    = 4;
    localparam int cpu_fbw_pos    = 6;
    localparam int cpu_fsr_pos    = 8;
    localparam int cpu_fbr_pos    = 10;

    // pci control field positions
    localparam int pci_active_pos = 0;
    localparam int pci_lock_pos   = 1;
    localparam int pci_rank_pos   = 2;
    localparam int pci_park_pos   = 5;
    localparam int pci_order_pos  = 9;

    // reset values
    localparam logic [15:0] cpu_ctrl_reset = 16'h0000;
    localparam logic [15:0] pci_ctrl_reset = 16'h0000;

    // writable bits
    localparam logic [15:0] cpu_ctrl_wmask = 16'h0ffe;
    localparam logic [15:0] pci_ctrl_wmask = 16'h07fe;

    // flatten codes
    localparam logic [1:0] flat_always = 2'h2;
    localparam logic [1:0] flat_switch = 2'h3;

    // cpu park codes
    localparam logic [1:0] cpark_none = 2'h0;
    localparam logic [1:0] cpark_last = 2'h1;
    localparam logic [1:0] cpark_cpu0 = 2'h2;
    localparam logic [1:0] cpark_cpu1 = 2'h3;

    // pci order codes
    localparam logic [1:0] porder_fixed = 2'h0;
    localparam logic [1:0] porder_rr    = 2'h1;
    localparam logic [1:0] porder_mixed = 2'h2;

    // pci park codes
    localparam logic [3:0] ppark_last   = 4'h0;
    localparam logic [3:0] ppark_bridge = 4'h8;
    localparam logic [3:0] ppark_none   = 4'hf;

    // group of each pci agent (index 0..6 requesters, 7 bridge)
    localparam logic [15:0] group_map = 16'b11_11_10_10_01_01_00_00;

    typedef enum logic [2:0]
    {
        cpu_idle_st = 3'b001,
        cpu_busy_st = 3'b010,
        cpu_flat_st = 3'b100
    } cpu_state_type;

endpackage : arb_pkg

//--- rtl/host_bridge_dual_arbiters.sv
// Operation
// - burst read end applies its flatten field
// - single read end applies its flatten field
// - burst write end applies its flatten field
// - single write end applies its flatten field
// - flatten codes: none, always, on switch
// - cpu priority rotating or cpu0 fixed
// - cpu parking none, last, cpu0, cpu1
// - cpu active flag read-only system arbiter
// - pci scheme fixed, round robin, mixed
// - pci park last, bridge, or none
// - codes 1-7 park requester 6 down to 0
// - fixed hierarchy rotates descending agent ring
// - mixed hierarchy rotates four group ranking
// - lock hold parks locking master exclusively
// - lock hold off ignores lock state
// - pci active flag read-only system arbiter
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module host_bridge_dual_arbiters
    import arb_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // arbiter straps
    input  wire logic        cpu_arb_active_i,
    input  wire logic        pci_arb_active_i,
    // processor bus
    input  wire logic [1:0]  cpu_req_i,
    input  wire logic        cpu_cycle_end_i,
    input  wire logic        cpu_cycle_burst_i,
    input  wire logic        cpu_cycle_write_i,
    output logic      [1:0]  cpu_grant_o,
    output logic             cpu_flatten_o,
    // pci bus
    input  wire logic [7:0]  pci_req_i,
    input  wire logic        pci_lock_i,
    input  wire logic        pci_idle_i,
    output logic      [7:0]  pci_grant_o
);

    logic [15:0] cpu_ctrl, next_cpu_ctrl;
    logic [15:0] pci_ctrl, next_pci_ctrl;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic        cpu_active, pci_active;
    logic        apb_access, apb_hit;

    cpu_state_type cpu_state, next_cpu_state;
    logic [1:0]    next_cpu_grant;
    logic          next_cpu_flatten;
    logic          cpu_last, next_cpu_last;

    logic [7:0] next_pci_grant;
    logic [2:0] pci_last, next_pci_last;
    logic [7:0] rr_ptr, next_rr_ptr;
    logic       lock_held, next_lock_held;
    logic [2:0] lock_owner, next_lock_owner;

    // cpu flatten field chosen by cycle type
    function automatic logic [1:0] flat_field(input logic [15:0] c,
        input logic burst, input logic write);
        if (burst && !write)
            flat_field = c[cpu_fbr_pos +: 2];
        else if (!burst && !write)
            flat_field = c[cpu_fsr_pos +: 2];
        else if (burst)
            flat_field = c[cpu_fbw_pos +: 2];
        else
            flat_field = c[cpu_fsw_pos +: 2];
    endfunction : flat_field

    // agent index to descending ring position (agent 6 at 0, bridge 7)
    function automatic logic [2:0] ring_pos(input logic [2:0] a);
        if (a == 3'h7)
            ring_pos = 3'h7;
        else
            ring_pos = 3'h6 - a;
    endfunction : ring_pos

    // pci priority score, smaller wins
    function automatic logic [5:0] pci_score(input logic [2:0] a,
        input logic [15:0] c, input logic [7:0] ptr);
        logic [2:0] rank;
        logic [1:0] grp;
        logic [1:0] gpos;
        rank = c[pci_rank_pos +: 3];
        grp  = group_map[2*a +: 2];
        pci_score = 6'h3f;
        if (c[pci_order_pos +: 2] == porder_fixed)
            pci_score = {3'h0, 3'(ring_pos(a) + rank)};
        else if (c[pci_order_pos +: 2] == porder_rr)
            pci_score = {3'h0, 3'(a - ptr[2:0])};
        else if (c[pci_order_pos +: 2] == porder_mixed)
        begin
            gpos = 2'(grp + rank[1:0]);
            pci_score = {1'b0, gpos, 3'(a - ptr[2:0])};
        end
    endfunction : pci_score

    assign cpu_active = cpu_arb_active_i;
    assign pci_active = pci_arb_active_i;
    assign apb_access = psel_i && penable_i && !pready_o;
    assign apb_hit    = paddr_i == cpu_ctrl_offset
                     || paddr_i == pci_ctrl_offset;

    // register bus
    always_comb
    begin
        next_cpu_ctrl = cpu_ctrl;
        next_pci_ctrl = pci_ctrl;
        next_cpu_ctrl[cpu_active_pos] = cpu_active;
        next_pci_ctrl[pci_active_pos] = pci_active;
        next_prdata  = prdata_o;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (apb_access)
        begin
            next_pready  = 1'b1;
            next_pslverr = !apb_hit;
            next_prdata  = 32'h0;
            if (paddr_i == cpu_ctrl_offset)
            begin
                if (pwrite_i)
                    next_cpu_ctrl = (cpu_ctrl & ~cpu_ctrl_wmask)
                                  | (pwdata_i[15:0] & cpu_ctrl_wmask);
                else
                    next_prdata = {16'h0, cpu_ctrl};
            end
            else if (paddr_i == pci_ctrl_offset)
            begin
                if (pwrite_i)
                    next_pci_ctrl = (pci_ctrl & ~pci_ctrl_wmask)
                                  | (pwdata_i[15:0] & pci_ctrl_wmask);
                else
                    next_prdata = {16'h0, pci_ctrl};
            end
            next_cpu_ctrl[cpu_active_pos] = cpu_active;
            next_pci_ctrl[pci_active_pos] = pci_active;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cpu_ctrl  <= cpu_ctrl_reset;
            pci_ctrl  <= pci_ctrl_reset;
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            cpu_ctrl  <= next_cpu_ctrl;
            pci_ctrl  <= next_pci_ctrl;
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // processor bus arbiter
    always_comb
    begin
        logic [1:0] park, code;
        logic       win, any;
        park = cpu_ctrl[cpu_park_pos +: 2];
        any  = |cpu_req_i;
        win  = 1'b0;
        code = 2'h0;
        if (cpu_ctrl[cpu_order_pos] && cpu_req_i == 2'b11)
            win = !cpu_last;
        else
            win = !cpu_req_i[0];
        next_cpu_state   = cpu_state;
        next_cpu_grant   = cpu_grant_o;
        next_cpu_flatten = 1'b0;
        next_cpu_last    = cpu_last;
        case (cpu_state)
            cpu_idle_st:
            begin
                if (any)
                begin
                    next_cpu_grant = win ? 2'b10 : 2'b01;
                    next_cpu_last  = win;
                    next_cpu_state = cpu_busy_st;
                end
                else if (park == cpark_last)
                    next_cpu_grant = cpu_last ? 2'b10 : 2'b01;
                else if (park == cpark_cpu0)
                    next_cpu_grant = 2'b01;
                else if (park == cpark_cpu1)
                    next_cpu_grant = 2'b10;
                else
                    next_cpu_grant = 2'b00;
            end
            cpu_busy_st:
            begin
                if (cpu_cycle_end_i)
                begin
                    code = flat_field(cpu_ctrl, cpu_cycle_burst_i,
                                      cpu_cycle_write_i);
                    next_cpu_state = cpu_idle_st;
                    if (code == flat_always
                        || (code == flat_switch
                            && cpu_req_i[~cpu_last]))
                    begin
                        next_cpu_grant   = 2'b00;
                        next_cpu_flatten = 1'b1;
                        next_cpu_state   = cpu_flat_st;
                    end
                end
            end
            cpu_flat_st:
                next_cpu_state = cpu_idle_st;
            default:
                next_cpu_state = cpu_idle_st;
        endcase
        if (!cpu_active)
        begin
            next_cpu_grant   = 2'b00;
            next_cpu_flatten = 1'b0;
            next_cpu_state   = cpu_idle_st;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cpu_state     <= cpu_idle_st;
            cpu_grant_o   <= 2'b00;
            cpu_flatten_o <= 1'b0;
            cpu_last      <= 1'b0;
        end
        else
        begin
            cpu_state     <= next_cpu_state;
            cpu_grant_o   <= next_cpu_grant;
            cpu_flatten_o <= next_cpu_flatten;
            cpu_last      <= next_cpu_last;
        end
    end

    // pci arbiter, re-arbitrates while the bus is idle
    always_comb
    begin
        logic [5:0] best;
        logic [2:0] sel;
        logic [3:0] park;
        logic       found;
        best  = 6'h3f;
        sel   = 3'h0;
        found = 1'b0;
        park  = pci_ctrl[pci_park_pos +: 4];
        for (int i = 0; i < 8; i++)
        begin
            if (pci_req_i[i] && pci_score(3'(i), pci_ctrl, rr_ptr) < best)
            begin
                best  = pci_score(3'(i), pci_ctrl, rr_ptr);
                sel   = 3'(i);
                found = 1'b1;
            end
        end
        next_pci_grant  = pci_grant_o;
        next_pci_last   = pci_last;
        next_rr_ptr     = rr_ptr;
        next_lock_held  = lock_held;
        next_lock_owner = lock_owner;
        if (pci_ctrl[pci_lock_pos] && pci_lock_i && !lock_held
            && pci_grant_o != 8'h0)
        begin
            next_lock_held  = 1'b1;
            next_lock_owner = pci_last;
        end
        else if (lock_held && (!pci_lock_i || !pci_ctrl[pci_lock_pos]))
            next_lock_held = 1'b0;
        if (next_lock_held)
            next_pci_grant = 8'(1) << next_lock_owner;
        else if (pci_idle_i)
        begin
            if (found)
            begin
                next_pci_grant = 8'(1) << sel;
                next_pci_last  = sel;
                next_rr_ptr    = 8'(3'(sel + 3'h1));
            end
            else if (park == ppark_last)
                next_pci_grant = 8'(1) << pci_last;
            else if (park == ppark_bridge)
                next_pci_grant = 8'h80;
            else if (park >= 4'h1 && park <= 4'h7)
                next_pci_grant = 8'(1) << 3'(4'h7 - park);
            else
                next_pci_grant = 8'h00;
        end
        if (!pci_active)
        begin
            next_pci_grant = 8'h00;
            next_lock_held = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pci_grant_o <= 8'h00;
            pci_last    <= 3'h7;
            rr_ptr      <= 8'h0;
            lock_held   <= 1'b0;
            lock_owner  <= 3'h0;
        end
        else
        begin
            pci_grant_o <= next_pci_grant;
            pci_last    <= next_pci_last;
            rr_ptr      <= next_rr_ptr;
            lock_held   <= next_lock_held;
            lock_owner  <= next_lock_owner;
        end
    end

    // checks
    property p_cpu_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        !cpu_active |=> cpu_grant_o == 2'b00;
    endproperty
    a_cpu_off: assert property (p_cpu_off)
        else $error("cpu grant while inactive");

    property p_pci_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        !pci_active |=> pci_grant_o == 8'h00;
    endproperty
    a_pci_off: assert property (p_pci_off)
        else $error("pci grant while inactive");

    property p_cpu_onehot;
        @(posedge sys_clk_i) disable iff (rst_i)
        $onehot0(cpu_grant_o);
    endproperty
    a_cpu_onehot: assert property (p_cpu_onehot)
        else $error("two cpu grants");

    property p_pci_onehot;
        @(posedge sys_clk_i) disable iff (rst_i)
        $onehot0(pci_grant_o);
    endproperty
    a_pci_onehot: assert property (p_pci_onehot)
        else $error("two pci grants");

    property p_cpu_fixed;
        @(posedge sys_clk_i) disable iff (rst_i)
        cpu_active && cpu_state == cpu_idle_st && cpu_req_i == 2'b11
        && !cpu_ctrl[cpu_order_pos] |=> cpu_grant_o == 2'b01;
    endproperty
    a_cpu_fixed: assert property (p_cpu_fixed)
        else $error("cpu0 not preferred");

    property p_park0;
        @(posedge sys_clk_i) disable iff (rst_i)
        cpu_active && cpu_state == cpu_idle_st && cpu_req_i == 2'b00
        && cpu_ctrl[cpu_park_pos +: 2] == cpark_cpu0
        |=> cpu_grant_o == 2'b01;
    endproperty
    a_park0: assert property (p_park0)
        else $error("no park on cpu0");

    property p_flat;
        @(posedge sys_clk_i) disable iff (rst_i)
        cpu_active && cpu_state == cpu_busy_st && cpu_cycle_end_i
        && flat_field(cpu_ctrl, cpu_cycle_burst_i, cpu_cycle_write_i)
           == flat_always
        |=> cpu_flatten_o ##1 !cpu_flatten_o;
    endproperty
    a_flat: assert property (p_flat)
        else $error("flatten not applied");

    property p_bridge_park;
        @(posedge sys_clk_i) disable iff (rst_i)
        pci_active && pci_idle_i && pci_req_i == 8'h00 && !lock_held
        && pci_ctrl[pci_park_pos +: 4] == ppark_bridge
        |=> pci_grant_o == 8'h80;
    endproperty
    a_bridge_park: assert property (p_bridge_park)
        else $error("no park on bridge");

    property p_lock;
        @(posedge sys_clk_i) disable iff (rst_i)
        pci_active && lock_held && pci_lock_i && pci_ctrl[pci_lock_pos]
        |=> pci_grant_o == $past(pci_grant_o);
    endproperty
    a_lock: assert property (p_lock)
        else $error("grant moved under lock");

    c_flat: cover property (@(posedge sys_clk_i) cpu_flatten_o);
    c_lock: cover property (@(posedge sys_clk_i) lock_held);
    c_cpu1: cover property (@(posedge sys_clk_i) cpu_grant_o == 2'b10);
    c_mix: cover property (@(posedge sys_clk_i)
        pci_ctrl[pci_order_pos +: 2] == porder_mixed && |pci_grant_o);

endmodule : host_bridge_dual_arbiters
`default_nettype wire

//--- bench/cpu_agents.sv
`timescale 1ns/100ps
`default_nettype none
// two processors: a request is held until granted, and the tenure
// ends with a one-cycle end pulse after a fixed number of cycles
module cpu_agents
#(
    parameter int tenure = 4
)
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // bench side
    input  wire logic [1:0] want_i,
    input  wire logic       burst_i,
    input  wire logic       write_i,
    // bus side
    input  wire logic [1:0] grant_i,
    output logic      [1:0] req_o,
    output logic            end_o,
    output logic            burst_o,
    output logic            write_o
);
    logic [3:0] cnt;

    // qualifiers are only valid with the end pulse
    assign burst_o = end_o ? burst_i : ~burst_i;
    assign write_o = end_o ? write_i : ~write_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_o <= 2'b00;
            end_o <= 1'b0;
            cnt   <= 4'h0;
        end
        else
        begin
            end_o <= 1'b0;
            if (end_o)
                req_o <= want_i & ~grant_i;
            else if ((grant_i & req_o) != 2'b00)
            begin
                cnt <= cnt + 4'h1;
                if (cnt == 4'(tenure))
                begin
                    end_o <= 1'b1;
                    cnt   <= 4'h0;
                end
            end
            else
                req_o <= want_i;
        end
    end
endmodule : cpu_agents
`default_nettype wire

//--- bench/host_bridge_dual_arbiters_test.sv
`timescale 1ns/100ps
`default_nettype none
module host_bridge_dual_arbiters_test;
    import arb_pkg::*;
    typedef struct packed
    {
        logic [32:0] val;
        logic [32:0] msk;
    } note_type;
    localparam logic [32:0] m_all = {33{1'b1}};
    localparam logic [32:0] m_err = {1'b1, 32'h0};
    localparam logic [32:0] m_act = {1'b0, 32'h1};
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic        c_act, p_act, c_end, c_burst, c_write, burst, write;
    logic        flat, lock, idle, look;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  creq, cgnt, want;
    logic [7:0]  preq, pgnt;
    logic [32:0] obs;
    logic [15:0] lfsr_state;
    note_type    q[$];
    note_type    nt;
    int          n_fail, checks_done, i, k;
    int          ring[8] = '{6, 5, 4, 3, 2, 1, 0, 7};
    logic [7:0]  mix[4] = '{8'h01, 8'h40, 8'h10, 8'h04};
    logic [1:0]  cpk[4] = '{2'b10, 2'b01, 2'b10, 2'b00};

    host_bridge_dual_arbiters i_host_bridge_dual_arbiters
    (
        .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cpu_arb_active_i(c_act), .pci_arb_active_i(p_act),
        .cpu_req_i(creq), .cpu_cycle_end_i(c_end),
        .cpu_cycle_burst_i(c_burst), .cpu_cycle_write_i(c_write),
        .cpu_grant_o(cgnt), .cpu_flatten_o(flat), .pci_req_i(preq),
        .pci_lock_i(lock), .pci_idle_i(idle), .pci_grant_o(pgnt)
    );

    cpu_agents i_cpu_agents
    (
        .clk_i(clk), .rst_i(rst), .want_i(want), .burst_i(burst),
        .write_i(write), .grant_i(cgnt), .req_o(creq), .end_o(c_end),
        .burst_o(c_burst), .write_o(c_write)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [31:0] pw(input logic [1:0] o,
        input logic [3:0] p, input logic [2:0] r, input logic l);
        pw = {21'h0, o, p, r, l, 1'b0};
    endfunction : pw

    task automatic final_report;
        if (q.size() != 0)
            n_fail++;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // compares each result on the outputs with the oldest note
    always @(negedge clk)
    begin
        obs = pready ? {pslverr, prdata} : {22'h0, flat, cgnt, pgnt};
        if (pready || look)
        begin
            if (q.size() == 0)
                check(obs, ~obs);
            else
            begin
                nt = q.pop_front();
                check(obs & nt.msk, nt.val & nt.msk);
            end
        end
    end

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int j;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (j = 0; j < 20 && pready !== 1'b1; j++)
            @(posedge clk);
        if (j == 20)
        begin
            n_fail++;
            final_report();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
        q.push_back('{e, m});
        apb(w, a, d);
    endtask : xfer

    task automatic expect_out(input logic [10:0] e);
        q.push_back('{{22'h0, e}, m_all});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : expect_out

    task automatic wait_for(input logic sel);
        int j;
        for (j = 0; j < 50; j++)
        begin
            @(posedge clk);
            if (sel ? c_end : (cgnt != 2'b00))
                break;
        end
        if (j == 50)
        begin
            n_fail++;
            final_report();
        end
    endtask : wait_for

    task automatic pgrant(input logic [7:0] r, input logic [7:0] e);
        @(posedge clk);
        preq <= r;
        repeat (2) @(posedge clk);
        expect_out({3'h0, e});
    endtask : pgrant

    task automatic tenure(input int t, input logic f);
        @(posedge clk);
        burst <= t[0];
        write <= !t[1];
        want  <= 2'b01;
        wait_for(1'b0);
        want  <= 2'b00;
        wait_for(1'b1);
        expect_out({f, 1'b0, !f, 8'h00});
    endtask : tenure

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, burst, write} = '0;
        {want, preq, lock, look, n_fail, checks_done} = '0;
        {rst, c_act, p_act, idle} = 4'hf;
        lfsr_state = 16'h0002;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        xfer(0, cpu_ctrl_offset, 0, {17'h0, cpu_ctrl_reset | 16'h1}, m_all);
        xfer(0, pci_ctrl_offset, 0, {17'h0, pci_ctrl_reset | 16'h1}, m_all);
        for (i = 0; i < 4; i++)
        begin
            lfsr_state = lfsr(lfsr_state);
            xfer(1, cpu_ctrl_offset, {2{lfsr_state}}, 33'h0, m_err);
            xfer(0, cpu_ctrl_offset, 0,
                 {17'h0, lfsr_state & cpu_ctrl_wmask | 16'h1}, m_all);
            xfer(1, pci_ctrl_offset, {2{lfsr_state}}, 33'h0, m_err);
            xfer(0, pci_ctrl_offset, 0,
                 {17'h0, lfsr_state & pci_ctrl_wmask | 16'h1}, m_all);
        end
        xfer(1, 12'h008, '1, m_err, m_err);
        xfer(0, 12'h008, 0, m_err, m_all);
        xfer(1, cpu_ctrl_offset, 0, 33'h0, m_err);
        $display("register test done");
        c_act <= 1'b0;
        p_act <= 1'b0;
        xfer(0, cpu_ctrl_offset, 0, 33'h0, m_act);
        xfer(0, pci_ctrl_offset, 0, 33'h0, m_act);
        want <= 2'b01;
        pgrant(8'hff, 8'h00);
        want <= 2'b00;
        @(posedge clk);
        {c_act, p_act} <= 2'b11;
        $display("inactive test done");
        for (k = 0; k < 8; k++)
        begin
            xfer(1, pci_ctrl_offset, pw(porder_fixed, ppark_none, 3'(k), 0),
                 33'h0, m_err);
            pgrant(8'hff, 8'h01 << ring[(8 - k) % 8]);
        end
        idle <= 1'b0;
        pgrant(8'h40, 8'h20);
        idle <= 1'b1;
        for (k = 1; k < 9; k++)
        begin
            xfer(1, pci_ctrl_offset, pw(porder_fixed, 4'(k), 0, 0), 33'h0, m_err);
            pgrant(8'h00, 8'h01 << ((15 - k) % 8));
        end
        xfer(1, pci_ctrl_offset, pw(porder_fixed, ppark_last, 0, 0), 33'h0, m_err);
        pgrant(8'h08, 8'h08);
        pgrant(8'h00, 8'h08);
        xfer(1, pci_ctrl_offset, pw(porder_fixed, ppark_none, 0, 0), 33'h0, m_err);
        pgrant(8'h00, 8'h00);
        for (k = 0; k < 4; k++)
        begin
            xfer(1, pci_ctrl_offset, pw(porder_mixed, ppark_none, 3'(k), 0),
                 33'h0, m_err);
            pgrant(8'h55, mix[k]);
        end
        xfer(1, pci_ctrl_offset, pw(porder_rr, ppark_none, 0, 0),
             33'h0, m_err);
        pgrant(8'h08, 8'h08);
        pgrant(8'h0b, 8'h02);
        xfer(1, pci_ctrl_offset, pw(2'b11, ppark_none, 0, 0), 33'h0, m_err);
        pgrant(8'hff, 8'h00);
        for (k = 1; k >= 0; k--)
        begin
            xfer(1, pci_ctrl_offset, pw(porder_fixed, ppark_none, 0, k[0]),
                 33'h0, m_err);
            pgrant(8'h08, 8'h08);
            lock <= 1'b1;
            pgrant(8'h48, k[0] ? 8'h08 : 8'h40);
            lock <= 1'b0;
            pgrant(8'h48, 8'h40);
        end
        preq <= 8'h00;
        xfer(1, pci_ctrl_offset, pw(porder_fixed, ppark_none, 0, 0), 33'h0, m_err);
        $display("pci test done");
        want <= 2'b11;
        wait_for(1'b0);
        expect_out(11'h100);
        want <= 2'b10;
        wait_for(1'b1);
        wait_for(1'b0);
        expect_out(11'h200);
        want <= 2'b00;
        wait_for(1'b1);
        for (k = 0; k < 4; k++)
        begin
            xfer(1, cpu_ctrl_offset, 32'((k + 1) % 4 << 1), 33'h0, m_err);
            repeat (3) @(posedge clk);
            expect_out({1'b0, cpk[k], 8'h00});
        end
        for (k = 0; k < 4; k++)
        begin
            xfer(1, cpu_ctrl_offset, 32'(2 << (4 + 2 * k)), 33'h0, m_err);
            tenure(k, 1'b1);
            tenure((k + 1) % 4, 1'b0);
            xfer(1, cpu_ctrl_offset, 32'(1 << (4 + 2 * k)), 33'h0, m_err);
            tenure(k, 1'b0);
        end
        xfer(1, cpu_ctrl_offset, 32'h0000_0c08, 33'h0, m_err);
        burst <= 1'b1;
        write <= 1'b0;
        want  <= 2'b11;
        wait_for(1'b0);
        expect_out(11'h200);
        want  <= 2'b01;
        wait_for(1'b1);
        expect_out(11'h400);
        wait_for(1'b0);
        want  <= 2'b00;
        wait_for(1'b1);
        tenure(3, 1'b0);
        $display("cpu test done");
        final_report();
    end
endmodule : host_bridge_dual_arbiters_test
`default_nettype wire
